// File: drs_controller.sv
// Controller end: refresh timing, credit and command issue
`timescale 1ns/100ps
`include "drs_consts.svh"
module drs_controller import drs_pkg::*; #(
   parameter int REFI_CYC = `DRS_REFI_CYC
) (
   // Clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       arst_n_in,
   // User request
   input  wire drs_op_type op_in,
   input  wire logic       op_all_in,
   input  wire logic [2:0] op_bank_in,
   input  wire logic       op_valid_in,
   input  wire logic       per_bank_mode_in,
   input  wire logic       modified_in,
   input  wire logic [2:0] refresh_rate_code_in,
   // Link
   drs_link_if.ctrl        link,
   // Status
   output logic            op_ready_out,
   output logic            op_reject_out,
   output logic signed [7:0] credit_out,
   output logic            refresh_due_out
);
   typedef struct packed {
      logic [2:0]  div;
      logic        ck;
      logic        rst_n;
      logic [1:0]  phase;
      logic [5:0]  ca;
      logic        cs;
      logic [5:0]  ca2;
      logic        cs2;
      logic [15:0] rfcab_t, rfcpb_t, rrd_t;
      logic [7:0][15:0] rp_t;
      logic [7:0]  open;
      logic [7:0]  done;
      logic [2:0]  count;
      logic [17:0] refi_t;
      logic signed [7:0] credit;
      logic [7:0]  win_cnt;
      logic [18:0] win_t;
      logic        sref;
      logic        rdy, rej;
   } drs_ctl_st_type;
   drs_ctl_st_type st_reg, st_next;
   logic signed [7:0] lim;
   logic [17:0] refi_scaled;
   logic ok;

   // Credit limit per rate code and constraint table
   function automatic logic signed [7:0] limit_of(input logic [2:0] code,
         input logic modi, input logic pb);
      logic signed [7:0] l;
      l = 8'sh08;
      if (modi && code == 3'h1) l = 8'sh02;
      if (modi && code == 3'h2) l = 8'sh04;
      if (pb) l = 8'(l * 8);
      return l;
   endfunction

   always_comb begin
      lim = limit_of(refresh_rate_code_in, modified_in, per_bank_mode_in);
      unique case (refresh_rate_code_in)
         3'h1: refi_scaled = 18'(REFI_CYC * 4);
         3'h2: refi_scaled = 18'(REFI_CYC * 2);
         3'h4: refi_scaled = 18'(REFI_CYC / 2);
         3'h5, 3'h6: refi_scaled = 18'(REFI_CYC / 4);
         default: refi_scaled = 18'(REFI_CYC);
      endcase
      if (per_bank_mode_in) refi_scaled = refi_scaled >> 3;
   end

   // Legality of the requested command
   always_comb begin
      ok = 1'b1;
      unique case (op_in)
         DRS_REF: begin
            if (op_all_in) begin
               ok = st_reg.open == 8'h00 && st_reg.rfcab_t == 0 &&
                    st_reg.rfcpb_t == 0 && st_reg.rp_t == '0 &&
                    st_reg.rrd_t == 0;
            end else begin
               ok = !st_reg.open[op_bank_in] && st_reg.rfcab_t == 0 &&
                    st_reg.rfcpb_t == 0 && st_reg.rp_t[op_bank_in] == 0 &&
                    st_reg.rrd_t == 0 &&
                    !st_reg.done[op_bank_in];
            end
            if (st_reg.credit >= lim) ok = 1'b0;
            if (st_reg.win_cnt >= 8'(per_bank_mode_in ? 128 : 16))
               ok = 1'b0;
         end
         DRS_ACT: ok = st_reg.rfcab_t == 0 && st_reg.rfcpb_t == 0 &&
                       st_reg.rrd_t == 0;
         DRS_SRE: ok = st_reg.credit >= -lim;
         default: ok = 1'b1;
      endcase
   end

   always_comb begin
      st_next = st_reg;
      st_next.rst_n = 1'b1;
      st_next.rdy = 1'b0;
      st_next.rej = 1'b0;
      // Link clock from a divider; commands change on falling edges
      st_next.div = st_reg.div + 3'h1;
      if (st_reg.div == 3'(`DRS_LINK_DIV - 1)) begin
         st_next.div = 3'h0;
         st_next.ck = ~st_reg.ck;
         if (st_reg.ck) begin
            st_next.phase = st_reg.phase == 2'h0 ? 2'h0 : st_reg.phase - 2'h1;
            st_next.cs = st_reg.phase == 2'h2 ? st_reg.cs2 : 1'b0;
            st_next.ca = st_reg.phase == 2'h2 ? st_reg.ca2 : 6'h00;
            if (st_reg.phase == 2'h1) st_next.rdy = 1'b1;
         end
      end
      if (st_reg.rfcab_t != 0) st_next.rfcab_t = st_reg.rfcab_t - 16'h1;
      if (st_reg.rfcpb_t != 0) st_next.rfcpb_t = st_reg.rfcpb_t - 16'h1;
      if (st_reg.rrd_t != 0) st_next.rrd_t = st_reg.rrd_t - 16'h1;
      for (int b = 0; b < 8; b++)
         if (st_reg.rp_t[b] != 0) st_next.rp_t[b] = st_reg.rp_t[b] - 16'h1;
      // Owed refresh accrues each interval, frozen in self refresh
      if (!st_reg.sref) begin
         if (st_reg.refi_t >= refi_scaled - 18'h1) begin
            st_next.refi_t = 18'h0;
            if (st_reg.credit > -lim)
               st_next.credit = st_reg.credit - 8'sh01;
         end else begin
            st_next.refi_t = st_reg.refi_t + 18'h1;
         end
      end
      if (st_reg.win_t >= 19'(refi_scaled * 2)) begin
         st_next.win_t = 19'h0;
         st_next.win_cnt = 8'h0;
      end else begin
         st_next.win_t = st_reg.win_t + 19'h1;
      end
      // Launch only on a link clock fall, so each frame half spans one
      // whole link period; a mid-period launch would be cut short
      if (op_valid_in && st_reg.phase == 2'h0 && !st_reg.rdy &&
          st_reg.ck && st_reg.div == 3'(`DRS_LINK_DIV - 1)) begin
         if (!ok) begin
            st_next.rej = 1'b1;
         end else begin
            st_next.phase = 2'h2;
            st_next.cs2 = 1'b0;
            st_next.ca2 = {3'h0, op_bank_in};
            unique case (op_in)
               DRS_REF: begin
                  st_next.ca[2:0] = `DRS_OP_REF;
                  // Build on this cycle's window and interval updates
                  st_next.win_cnt = st_next.win_cnt + 8'h1;
                  if (st_next.credit < lim)
                     st_next.credit = st_next.credit + 8'sh01;
                  if (op_all_in) begin
                     st_next.rfcab_t = 16'(`DRS_RFCAB_CYC);
                     st_next.count = 3'h0;
                     st_next.done = 8'h00;
                  end else begin
                     st_next.rfcpb_t = 16'(`DRS_RFCPB_CYC);
                     st_next.rrd_t = 16'(`DRS_RRD_CYC);
                     st_next.count = st_reg.count + 3'h1;
                     st_next.done[op_bank_in] = 1'b1;
                     if (st_reg.done == ~(8'h1 << op_bank_in))
                        st_next.done = 8'h00;
                  end
               end
               DRS_ACT: begin
                  st_next.ca[2:0] = `DRS_OP_ACT;
                  st_next.open[op_bank_in] = 1'b1;
                  st_next.rrd_t = 16'(`DRS_RRD_CYC);
               end
               DRS_PRE: begin
                  st_next.ca[2:0] = `DRS_OP_PRE;
                  for (int b = 0; b < 8; b++)
                     if (op_all_in || op_bank_in == 3'(b)) begin
                        st_next.open[b] = 1'b0;
                        st_next.rp_t[b] = 16'(`DRS_RP_CYC);
                     end
               end
               DRS_SRE: begin
                  st_next.ca[2:0] = `DRS_OP_SRE;
                  st_next.sref = 1'b1;
               end
               DRS_SRX: begin
                  st_next.ca[2:0] = `DRS_OP_SRX;
                  st_next.sref = 1'b0;
                  st_next.count = 3'h0;
                  st_next.done = 8'h00;
               end
               default: st_next.ca[2:0] = `DRS_OP_RW;
            endcase
            st_next.ca[`DRS_OP_ALL_BIT] = op_all_in;
            st_next.ca[5:4] = 2'h0;
            st_next.cs = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign link.ck = st_reg.ck;
   assign link.reset_n = st_reg.rst_n;
   assign link.ca = st_reg.ca;
   assign link.cs = st_reg.cs;
   assign op_ready_out = st_reg.rdy;
   assign op_reject_out = st_reg.rej;
   assign credit_out = st_reg.credit;
   assign refresh_due_out = st_reg.credit[7];   // Sign bit: refreshes owed
endmodule // drs_controller

// File: drs_consts.svh
// Timing counts and field positions for the refresh scheduling link
`ifndef DRS_CONSTS_SVH
`define DRS_CONSTS_SVH
`define DRS_CLK_NS          25
`define DRS_RFCAB_NS        280
`define DRS_RFCPB_NS        140
`define DRS_RP_NS           18
`define DRS_RRD_NS          10
`define DRS_REFI_NS         3904
`define DRS_RFCAB_CYC       ((`DRS_RFCAB_NS + `DRS_CLK_NS - 1) / `DRS_CLK_NS)
`define DRS_RFCPB_CYC       ((`DRS_RFCPB_NS + `DRS_CLK_NS - 1) / `DRS_CLK_NS)
`define DRS_RP_CYC          ((`DRS_RP_NS + `DRS_CLK_NS - 1) / `DRS_CLK_NS)
`define DRS_RRD_CYC         ((`DRS_RRD_NS + `DRS_CLK_NS - 1) / `DRS_CLK_NS)
`define DRS_REFI_CYC        (`DRS_REFI_NS / `DRS_CLK_NS)
`define DRS_LINK_DIV        4
`define DRS_NUM_BANKS       8
`define DRS_OP_REF          3'h1
`define DRS_OP_ACT          3'h2
`define DRS_OP_PRE          3'h3
`define DRS_OP_SRE          3'h4
`define DRS_OP_SRX          3'h5
`define DRS_OP_RW           3'h6
`define DRS_OP_ALL_BIT      3
`define DRS_BANK_LSB        0
`endif

// File: drs_pkg.sv
// Types shared by both ends of the refresh scheduling link
package drs_pkg;
   typedef enum logic [2:0] {
      DRS_NONE, DRS_REF, DRS_ACT, DRS_PRE, DRS_SRE, DRS_SRX, DRS_RW
   } drs_op_type;
endpackage

// File: drs_link_if.sv
// Command/address link between controller and device
`timescale 1ns/100ps
interface drs_link_if;
   logic       ck;        // Command clock from controller
   logic       reset_n;   // Device reset, active low
   logic [5:0] ca;        // Command/address lines
   logic       cs;        // Chip select, first command cycle
   modport ctrl (output ck, output reset_n, output ca, output cs);
   modport dev  (input ck, input reset_n, input ca, input cs);
endinterface

// File: drs_device.sv
// Device end: per-bank and all-bank refresh execution
`timescale 1ns/100ps
`include "drs_consts.svh"
module drs_device import drs_pkg::*; (
   // Clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       arst_n_in,
   // Link
   drs_link_if.dev         link,
   // Status
   output logic [7:0]      bank_busy_out,
   output logic [7:0]      bank_open_out,
   output logic [2:0]      bank_count_out,
   output logic            self_refresh_out,
   output logic            access_err_out
);
   typedef struct packed {
      logic [2:0]  ck_s;
      logic [1:0]  rst_s;
      logic [6:0]  cs_ca1, cs_ca2;
      logic        second;
      logic [5:0]  first_ca;
      logic [7:0]  busy;
      logic [7:0]  open;
      logic [7:0][7:0] timer;
      logic [2:0]  count;
      logic        sref;
      logic        err;
   } drs_dev_st_type;
   drs_dev_st_type st_reg, st_next;
   logic rise;
   assign rise = st_reg.ck_s[1] & ~st_reg.ck_s[2];

   // Decode commands on rising link clock edges
   always_comb begin
      st_next = st_reg;
      st_next.ck_s = {st_reg.ck_s[1:0], link.ck};
      st_next.rst_s = {st_reg.rst_s[0], link.reset_n};
      st_next.cs_ca1 = {link.cs, link.ca};
      st_next.cs_ca2 = st_reg.cs_ca1;
      st_next.err = 1'b0;
      for (int b = 0; b < 8; b++) begin
         if (st_reg.timer[b] != 8'h00) begin
            st_next.timer[b] = st_reg.timer[b] - 8'h01;
         end else if (st_reg.busy[b]) begin
            st_next.busy[b] = 1'b0;        // Bank left idle
            st_next.open[b] = 1'b0;
         end
      end
      if (rise) begin
         st_next.second = st_reg.cs_ca2[6];
         if (st_reg.cs_ca2[6]) begin
            st_next.first_ca = st_reg.cs_ca2[5:0];
         end else if (st_reg.second) begin
            unique case (st_reg.first_ca[2:0])
               `DRS_OP_REF: begin
                  if (st_reg.first_ca[`DRS_OP_ALL_BIT]) begin
                     st_next.busy = 8'hff;
                     st_next.timer = {8{8'(`DRS_RFCAB_CYC)}};
                     st_next.count = 3'h0;
                  end else begin
                     // Only the target bank is blocked
                     st_next.busy[st_reg.cs_ca2[2:0]] = 1'b1;
                     st_next.timer[st_reg.cs_ca2[2:0]] =
                        8'(`DRS_RFCPB_CYC);
                     st_next.count = st_reg.count + 3'h1;
                  end
               end
               `DRS_OP_ACT: begin
                  if (st_reg.busy[st_reg.cs_ca2[2:0]]) begin
                     st_next.err = 1'b1;
                  end else begin
                     st_next.open[st_reg.cs_ca2[2:0]] = 1'b1;
                  end
               end
               `DRS_OP_RW: begin
                  st_next.err = st_reg.busy[st_reg.cs_ca2[2:0]];
               end
               `DRS_OP_PRE: begin
                  if (st_reg.first_ca[`DRS_OP_ALL_BIT]) begin
                     st_next.open = 8'h00;
                  end else begin
                     st_next.open[st_reg.cs_ca2[2:0]] = 1'b0;
                  end
               end
               `DRS_OP_SRE: st_next.sref = 1'b1;
               `DRS_OP_SRX: begin
                  st_next.sref = 1'b0;
                  st_next.count = 3'h0;
               end
               default: ;
            endcase
         end
      end
      if (!st_reg.rst_s[1]) begin
         st_next.count = 3'h0;
         st_next.busy = 8'h00;
         st_next.open = 8'h00;
         st_next.sref = 1'b0;
      end
   end

   // State register
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign bank_busy_out = st_reg.busy;
   assign bank_open_out = st_reg.open;
   assign bank_count_out = st_reg.count;
   assign self_refresh_out = st_reg.sref;
   assign access_err_out = st_reg.err;
endmodule // drs_device

// File: drs_link_asserts.sv
// Link protocol checks between the controller and device ends
`timescale 1ns/100ps
`include "drs_consts.svh"
module drs_link_asserts (
   // Clock and reset
   input wire logic       core_clk_in,
   input wire logic       arst_n_in,
   // Link signals
   input wire logic       ck,
   input wire logic       reset_n,
   input wire logic [5:0] ca,
   input wire logic       cs
);
   localparam int RFCAB = `DRS_RFCAB_CYC;
   localparam int RFCPB = `DRS_RFCPB_CYC;
   logic       cs_reg;
   logic [2:0] op_reg;
   logic       all_reg;
   logic [7:0] open_reg;
   logic [7:0] done_reg;
   logic [7:0] gap_reg;
   logic       first_w;
   logic       second_w;
   logic       pb_w;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   // Frame edges decoded from chip select
   assign first_w  = cs && !cs_reg;
   assign second_w = !cs && cs_reg;
   assign pb_w     = second_w && op_reg == `DRS_OP_REF && !all_reg;
   // Bank state rebuilt from the wire alone, trusting neither end
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         {cs_reg, op_reg, all_reg, open_reg, done_reg, gap_reg} <= '0;
      end else begin
         cs_reg <= cs;
         gap_reg <= first_w ? 8'h00 : gap_reg + {7'h0, gap_reg != 8'hff};
         if (first_w) begin
            op_reg  <= ca[2:0];
            all_reg <= ca[`DRS_OP_ALL_BIT];
         end
         if (second_w && op_reg == `DRS_OP_ACT)
            open_reg[ca[2:0]] <= 1'b1;
         if (second_w && op_reg == `DRS_OP_PRE)
            open_reg <= all_reg ? 8'h00 : open_reg & ~(8'h01 << ca[2:0]);
         if (!reset_n || (second_w && op_reg == `DRS_OP_SRX) ||
             (second_w && op_reg == `DRS_OP_REF && all_reg))
            done_reg <= 8'h00;
         else if (pb_w)
            done_reg <= ((done_reg | (8'h01 << ca[2:0])) == 8'hff) ? 8'h00
                        : done_reg | (8'h01 << ca[2:0]);
      end
   end
   sequence s_cmd_cycle;
      cs [*8];
   endsequence
   sequence s_bank_cycle;
      !cs [*8];
   endsequence
   a_frame_shape: assert property (
      $rose(cs) |-> s_cmd_cycle ##1 s_bank_cycle)
      else $error("command frame length wrong");
   a_cmd_held: assert property (
      $rose(cs) |=> $stable(ca) [*7])
      else $error("command cycle lines moved");
   a_bank_held: assert property (
      $fell(cs) |=> $stable(ca) [*7])
      else $error("bank cycle lines moved");
   a_no_cmd_reset: assert property (
      cs |-> reset_n)
      else $error("command sent while device held in reset");
   a_ref_spacing: assert property (
      first_w && op_reg == `DRS_OP_REF &&
      (ca[2:0] == `DRS_OP_REF || ca[2:0] == `DRS_OP_ACT)
      |-> gap_reg >= (all_reg ? RFCAB : RFCPB))
      else $error("refresh cycle time not kept");
   a_all_bank_refresh_cmd_idle: assert property (
      second_w && op_reg == `DRS_OP_REF && all_reg |-> open_reg == 8'h00)
      else $error("all-bank refresh with a bank open");
   a_per_bank_refresh_cmd_idle: assert property (
      pb_w |-> !open_reg[ca[2:0]])
      else $error("per-bank refresh to an open bank");
   a_no_repeat: assert property (
      pb_w |-> !done_reg[ca[2:0]])
      else $error("per-bank refresh repeated before full round");
endmodule // drs_link_asserts

// File: test_dram_refresh_scheduling.sv
// Self-checking bench joining controller and device over the link
`timescale 1ns/100ps
`include "drs_consts.svh"
module test_dram_refresh_scheduling import drs_pkg::*; ;
   localparam int REFI = 2000;
   logic              clk;
   logic              arst_n;
   drs_op_type        op;
   logic              op_all;
   logic [2:0]        op_bank;
   logic              op_valid;
   logic              pb_mode;
   logic              modified;
   logic [2:0]        rate;
   logic              op_ready;
   logic              op_reject;
   logic signed [7:0] credit;
   logic              due;
   logic [7:0]        busy;
   logic [7:0]        bank_open;
   logic [2:0]        count;
   logic              sr;
   logic              acc_err;
   int                failures;
   int                n_tests;
   int                seed;
   logic [7:0]        m_open;
   logic [7:0]        m_done;
   int                m_cnt;
   int                m_credit;
   logic              m_sr;
   logic              m_ckc;
   logic [2:0]        perm [8];
   drs_link_if link ();
   drs_controller #(.REFI_CYC(REFI)) i_drs_controller (
      .core_clk_in(clk), .arst_n_in(arst_n), .op_in(op),
      .op_all_in(op_all), .op_bank_in(op_bank), .op_valid_in(op_valid),
      .per_bank_mode_in(pb_mode), .modified_in(modified),
      .refresh_rate_code_in(rate), .link(link), .op_ready_out(op_ready),
      .op_reject_out(op_reject), .credit_out(credit),
      .refresh_due_out(due));
   drs_device i_drs_device (
      .core_clk_in(clk), .arst_n_in(arst_n), .link(link),
      .bank_busy_out(busy), .bank_open_out(bank_open),
      .bank_count_out(count), .self_refresh_out(sr),
      .access_err_out(acc_err));
   drs_link_asserts i_drs_link_asserts (
      .core_clk_in(clk), .arst_n_in(arst_n), .ck(link.ck),
      .reset_n(link.reset_n), .ca(link.ca), .cs(link.cs));
   // Free-running core clock
   always #12.5 clk = ~clk;
   task automatic check(string name, logic [7:0] exp, logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic results();
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Credit ceiling for the present rate code and refresh style
   function automatic int lim();
      int l;
      l = (modified && rate == 3'h1) ? 2 : (modified && rate == 3'h2) ? 4 : 8;
      return pb_mode ? l * 8 : l;
   endfunction
   task automatic cmp();
      @(posedge clk);
      #1;
      check("count", 8'(m_cnt), {5'h0, count});
      check("open", m_open, bank_open);
      check("busy", 8'h00, busy);
      check("self_refresh", {7'h0, m_sr}, {7'h0, sr});
      if (m_ckc) check("credit", 8'(m_credit), credit);
      if (m_ckc) check("due", {7'h0, m_credit < 0}, {7'h0, due});
   endtask
   task automatic rst();
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      {m_open, m_done, m_sr} = '0;
      m_cnt = 0;
      m_credit = 0;
      m_ckc = 1'b1;
   endtask
   // One request, predicted by the model, then compared at the ports
   task automatic do_op(drs_op_type o, logic a, logic [2:0] b);
      logic ok;
      logic fin;
      logic [7:0] seen;
      logic err_seen;
      ok = (o != DRS_REF) || ((a ? m_open == 8'h00
                                 : !m_open[b] && !m_done[b])
                              && m_credit < lim());
      fin = 1'b0;
      seen = 8'h00;
      err_seen = 1'b0;
      @(posedge clk);
      op <= o;
      op_all <= a;
      op_bank <= b;
      op_valid <= 1'b1;
      for (int n = 0; n < 64 && !fin; n++) begin
         @(posedge clk);
         #1;
         seen = seen | busy;
         err_seen = err_seen | acc_err;
         fin = op_ready === 1'b1 || op_reject === 1'b1;
      end
      check("ready", {7'h0, ok}, {7'h0, op_ready});
      check("reject", {7'h0, !ok}, {7'h0, op_reject});
      @(posedge clk);
      op_valid <= 1'b0;
      repeat (16) begin
         @(posedge clk);
         #1;
         seen = seen | busy;
         err_seen = err_seen | acc_err;
      end
      if (ok) begin
         case (o)
            DRS_ACT: m_open[b] = 1'b1;
            DRS_PRE: m_open = a ? 8'h00 : m_open & ~(8'h01 << b);
            DRS_SRE: m_sr = 1'b1;
            DRS_SRX: {m_sr, m_cnt, m_done} = '0;
            DRS_REF: begin
               if (a == pb_mode)
                  m_ckc = 1'b0;
               else
                  m_credit++;
               m_done = a ? 8'h00 : m_done | (8'h01 << b);
               if (m_done == 8'hff)
                  m_done = 8'h00;
               m_cnt = a ? 0 : (m_cnt + 1) % 8;
            end
            default: ;
         endcase
      end
      if (o == DRS_REF && !a)
         check("busy_other", 8'h00, seen & ~(8'h01 << b));
      check("access_err", 8'h00, {7'h0, err_seen});
      cmp();
   endtask
   // Hang guard sized well past the longest sequence
   initial begin
      repeat (40 * REFI) @(posedge clk);
      failures++;
      results();
   end
   initial begin
      int j;
      logic [2:0] x;
      logic [2:0] t;
      {clk, arst_n, op_all, op_bank, op_valid, pb_mode, modified} = '0;
      op = DRS_NONE;
      rate = 3'h3;
      {failures, n_tests} = '0;
      seed = 74792;
      rst();
      cmp();
      // Pull-in ceiling for every usable code, legacy then modified
      for (int md = 0; md < 2; md++)
         for (int cd = 1; cd < 7; cd++) begin
            modified <= md[0];
            rate <= 3'(cd);
            rst();
            for (int i = 0; i <= lim(); i++)
               do_op(DRS_REF, 1'b1, 3'($random(seed)));
         end
      // Per-bank: open bank, repeats, shuffled round, resync
      // Slow rate keeps these sections inside one per-bank interval
      modified <= 1'b0;
      rate <= 3'h1;
      pb_mode <= 1'b1;
      rst();
      x = 3'($random(seed));
      do_op(DRS_ACT, 1'b0, x);
      do_op(DRS_REF, 1'b0, x);
      do_op(DRS_REF, 1'b1, x);
      do_op(DRS_REF, 1'b0, x + 3'h1);
      do_op(DRS_RW, 1'b0, x);
      do_op(DRS_PRE, 1'b1, x);
      for (int i = 0; i < 8; i++)
         perm[i] = 3'(i);
      for (int i = 7; i > 0; i--) begin
         j = ($random(seed) & 32'h7fffffff) % (i + 1);
         t = perm[i];
         perm[i] = perm[j];
         perm[j] = t;
      end
      for (int i = 0; i < 8; i++)
         do_op(DRS_REF, 1'b0, perm[i]);
      do_op(DRS_REF, 1'b0, perm[0]);
      do_op(DRS_REF, 1'b0, perm[0]);
      do_op(DRS_REF, 1'b1, x);
      do_op(DRS_REF, 1'b0, perm[0]);
      // Self refresh holds the credit across a full interval
      rst();
      do_op(DRS_REF, 1'b0, x);
      do_op(DRS_REF, 1'b0, x + 3'h1);
      do_op(DRS_SRE, 1'b0, x);
      repeat (REFI + 500) @(posedge clk);
      cmp();
      do_op(DRS_SRX, 1'b0, x);
      // Postponement: owed grows per interval, clamps at eight
      pb_mode <= 1'b0;
      rate <= 3'h3;
      rst();
      repeat (3 * REFI + REFI / 2) @(posedge clk);
      m_credit = -3;
      cmp();
      repeat (8 * REFI) @(posedge clk);
      m_credit = -8;
      cmp();
      do_op(DRS_REF, 1'b1, x);
      results();
   end
endmodule // test_dram_refresh_scheduling
